/* hdl/guard_soak_timer.sv */
// Purpose: Qualify and disqualify one reference from its failure level
// Assumes: tick_in is a one-cycle 0.5 ms pulse on the same clock
// Notes: Reference starts unqualified after reset
`timescale 1ns/1ps
module guard_soak_timer
  import tx_loop_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic fail_in,
  input wire logic [SOAK_DQ_W-1:0] dq_ticks_in,
  input wire logic [2:0] qm_shift_in,
  output logic qualified_out
);
  typedef struct packed {
    logic qualified;
    logic [SOAK_CNT_W-1:0] count;
  } soak_state_t;

  soak_state_t s_reg;
  soak_state_t s_next;
  logic [SOAK_CNT_W-1:0] dq_lim;
  logic [SOAK_CNT_W-1:0] q_lim;

  always_comb
  begin
    s_next = s_reg;
    dq_lim = {{(SOAK_CNT_W-SOAK_DQ_W){1'b0}}, dq_ticks_in};
    q_lim = dq_lim << qm_shift_in;
    if (s_reg.qualified)
    begin
      if (!fail_in)
        s_next.count = '0;
      else if (s_reg.count >= dq_lim)
      begin
        s_next.qualified = 1'b0;
        s_next.count = '0;
      end
      else if (tick_in)
        s_next.count = s_reg.count + 1'b1;
    end
    else
    begin
      if (fail_in)
        s_next.count = '0;
      else if (s_reg.count >= q_lim)
      begin
        s_next.qualified = 1'b1;
        s_next.count = '0;
      end
      else if (tick_in)
        s_next.count = s_reg.count + 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign qualified_out = s_reg.qualified;
endmodule

/* hdl/tx_dpll_mode_and_qualify_ctrl.sv */
// Purpose: Mode, selection and qualification control of the transmit loop
// Assumes: Failure, priority and rate inputs come from logic on clock_in
// Notes: Mode pin is synchronised and strapped after reset release
// Summary of operation
// - Disqualify delay from 4-bit code table
// - Qualify delay is disqualify times 2/4/16/32
// - Hitless off: build out phase on switch
// - Hitless on: realign phase on switch
// - 3-bit code selects loop bandwidth
// - 28 Hz capped at 14 Hz on 2 kHz
// - 890 Hz default, capped for 2k/8k
// - Phase slope limit code, unlimited default
// - Revert bit picks revertive switching
// - Offset enable applies free-run offset
// - Manual normal locks to selected reference
// - Manual normal failure enters holdover
// - Manual holdover stays in holdover
// - Manual free-run stays free-running
// - Automatic locks to best qualified reference
// - Active failure switches to next best
// - No qualified reference enters holdover
// - Packet client mode: software steers oscillator
// - Mode reset value follows mode pin
// - Refsel reports or selects reference 0..4
`timescale 1ns/1ps
module tx_dpll_mode_and_qualify_ctrl
  import tx_loop_pkg::*;
#(
  parameter int NUM_REFS = MAX_REFS,
  parameter int TICK_CYCLES = SOAK_TICK_CYCLES
)
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic mode_pin_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [NUM_REFS-1:0] ref_fail_in,
  input wire logic [NUM_REFS*4-1:0] ref_priority_in,
  input wire logic [NUM_REFS-1:0] ref_is_2khz_in,
  input wire logic [NUM_REFS-1:0] ref_is_8khz_in,
  output logic [7:0] rd_data_out,
  output logic [1:0] loop_state_out,
  output logic [3:0] active_ref_out,
  output logic [NUM_REFS-1:0] qualified_out,
  output logic [2:0] eff_bandwidth_out,
  output logic bw_limit_56hz_out,
  output logic [1:0] phase_slope_limit_code_out,
  output logic revertive_out,
  output logic freq_offset_apply_out,
  output logic software_dco_out,
  output logic ref_switch_out,
  output logic phase_buildout_out,
  output logic phase_realign_out
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  if (NUM_REFS < 1 || NUM_REFS > MAX_REFS || TICK_CYCLES < 1)
  begin : g_bad_params
    $error("Unsupported reference count or tick length");
  end

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] soak;
    logic [2:0] mode;
    logic [3:0] refsel;
    loop_state_t st;
    logic [3:0] active;
    logic sync1;
    logic sync2;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [7:0] rd_data;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic switch_p;
    logic buildout_p;
    logic realign_p;
    logic [2:0] eff_bw;
    logic lim56;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;
  logic [NUM_REFS-1:0] qual;
  logic [3:0] dq_code;
  logic [1:0] qm_code;

  assign dq_code = s_reg.soak[SOAK_DQ_LSB +: 4];
  assign qm_code = s_reg.soak[SOAK_QM_LSB +: 2];

  // One soak timer per reference input
  for (genvar g = 0; g < NUM_REFS; g++)
  begin : g_soak
    guard_soak_timer u_soak (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .tick_in(s_reg.tick),
      .fail_in(ref_fail_in[g]),
      .dq_ticks_in(DQ_TICKS[dq_code]),
      .qm_shift_in(QM_SHIFT[qm_code]),
      .qualified_out(qual[g])
    );
  end

  always_comb
  begin
    logic best_ok;
    logic [3:0] best_idx;
    logic [3:0] best_pri;
    logic [3:0] pri;
    logic [3:0] act_pri;
    logic act_ok;
    logic sel_ok;
    logic new_lock;
    logic [2:0] bw;
    logic is2k;
    logic is8k;
    s_next = s_reg;
    pri = 4'h0;
    new_lock = 1'b0;
    bw = 3'h0;
    best_ok = 1'b0;
    best_idx = 4'h0;
    best_pri = PRI_DISABLED;
    act_pri = PRI_DISABLED;
    act_ok = 1'b0;
    sel_ok = 1'b0;
    is2k = 1'b0;
    is8k = 1'b0;

    // Mode pin synchroniser and strap capture
    s_next.sync1 = mode_pin_in;
    s_next.sync2 = s_reg.sync1;
    if (!s_reg.strap_done)
    begin
      s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      if (s_reg.strap_cnt == STRAP_WAIT)
      begin
        s_next.mode = s_reg.sync2 ? MODE_STRAP_HIGH : MODE_STRAP_LOW;
        s_next.strap_done = 1'b1;
      end
    end

    // Soak tick prescaler
    if (s_reg.tick_cnt == TICK_LAST)
    begin
      s_next.tick_cnt = '0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.tick_cnt = s_reg.tick_cnt + 1'b1;
      s_next.tick = 1'b0;
    end

    // Register writes
    if (wr_en_in)
    begin
      case (addr_in)
        ADDR_SOAK_QUALIFY: s_next.soak = {2'h0, wr_data_in[5:0]};
        ADDR_CTRL_A:
        begin
          s_next.ctrl_a = {s_reg.ctrl_a[7:6], wr_data_in[5:0]};
          if (wr_data_in[CA_BW_LSB +: 3] == BW_RESERVED)
            s_next.ctrl_a[CA_BW_LSB +: 3] = s_reg.ctrl_a[CA_BW_LSB +: 3];
        end
        ADDR_CTRL_B: s_next.ctrl_b = {s_reg.ctrl_b[7:2], wr_data_in[1:0]};
        ADDR_MODE:
        begin
          if (wr_data_in[2:0] <= MODE_PACKET_CLIENT)
            s_next.mode = wr_data_in[2:0];
        end
        ADDR_REFSEL:
        begin
          if (s_reg.mode == MODE_MAN_NORMAL)
            s_next.refsel = wr_data_in[3:0];
        end
        default: s_next.rd_data = s_next.rd_data;
      endcase
    end

    // Register reads, unmapped reads as zero
    if (rd_en_in)
    begin
      case (addr_in)
        ADDR_SOAK_QUALIFY: s_next.rd_data = s_reg.soak;
        ADDR_CTRL_A: s_next.rd_data = s_reg.ctrl_a;
        ADDR_CTRL_B: s_next.rd_data = s_reg.ctrl_b;
        ADDR_MODE: s_next.rd_data = {5'h0, s_reg.mode};
        ADDR_REFSEL: s_next.rd_data = {4'h0, s_reg.refsel};
        default: s_next.rd_data = 8'h00;
      endcase
    end

    // Best qualified reference by priority, lower index wins ties
    for (int i = 0; i < NUM_REFS; i++)
    begin
      pri = ref_priority_in[i*4 +: 4];
      if (qual[i] && pri != PRI_DISABLED && (!best_ok || pri < best_pri))
      begin
        best_ok = 1'b1;
        best_idx = 4'(i);
        best_pri = pri;
      end
      if (4'(i) == s_reg.active)
      begin
        act_pri = pri;
        act_ok = qual[i] && pri != PRI_DISABLED;
      end
      if (4'(i) == s_reg.refsel)
        sel_ok = qual[i];
    end

    // Operating mode
    case (s_reg.mode)
      MODE_MAN_NORMAL:
      begin
        s_next.active = s_reg.refsel;
        s_next.st = sel_ok ? ST_LOCKED : ST_HOLDOVER;
      end
      MODE_MAN_HOLDOVER: s_next.st = ST_HOLDOVER;
      MODE_MAN_FREERUN: s_next.st = ST_FREERUN;
      MODE_AUTO:
      begin
        if (s_reg.st == ST_LOCKED && act_ok)
        begin
          if (s_reg.ctrl_b[CB_REVERT_BIT] && best_pri < act_pri)
            s_next.active = best_idx;
        end
        else if (best_ok)
        begin
          s_next.active = best_idx;
          s_next.st = ST_LOCKED;
        end
        else
          s_next.st = ST_HOLDOVER;
        s_next.refsel = s_next.active;
      end
      MODE_PACKET_CLIENT: s_next.st = ST_SOFT_DCO;
      default: s_next.st = ST_HOLDOVER;
    endcase

    // Switch events toward the phase path
    new_lock = s_next.st == ST_LOCKED && (s_reg.st != ST_LOCKED || s_next.active != s_reg.active);
    s_next.switch_p = new_lock;
    s_next.buildout_p = new_lock && !s_reg.ctrl_a[CA_HITLESS_BIT];
    s_next.realign_p = new_lock && s_reg.ctrl_a[CA_HITLESS_BIT];

    // Effective bandwidth for the active reference rate
    for (int i = 0; i < NUM_REFS; i++)
    begin
      if (4'(i) == s_next.active)
      begin
        is2k = ref_is_2khz_in[i];
        is8k = ref_is_8khz_in[i];
      end
    end
    bw = s_reg.ctrl_a[CA_BW_LSB +: 3];
    s_next.eff_bw = bw;
    s_next.lim56 = 1'b0;
    if (bw == BW_28HZ && is2k)
      s_next.eff_bw = BW_14HZ;
    if (bw == BW_890HZ && is2k)
      s_next.eff_bw = BW_14HZ;
    else if (bw == BW_890HZ && is8k)
      s_next.lim56 = 1'b1;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_reg <= '0;
      s_reg.ctrl_a <= RST_CTRL_A;
      s_reg.ctrl_b <= RST_CTRL_B;
      s_reg.soak <= RST_SOAK_QUALIFY;
      s_reg.mode <= MODE_MAN_HOLDOVER;
      s_reg.refsel <= RST_REFSEL;
      s_reg.st <= ST_HOLDOVER;
      s_reg.eff_bw <= BW_890HZ;
    end
    else
      s_reg <= s_next;
  end

  assign rd_data_out = s_reg.rd_data;
  assign loop_state_out = s_reg.st;
  assign active_ref_out = s_reg.active;
  assign qualified_out = qual;
  assign eff_bandwidth_out = s_reg.eff_bw;
  assign bw_limit_56hz_out = s_reg.lim56;
  assign phase_slope_limit_code_out = s_reg.ctrl_a[CA_SLOPE_LSB +: 2];
  assign revertive_out = s_reg.ctrl_b[CB_REVERT_BIT];
  assign freq_offset_apply_out = s_reg.ctrl_b[CB_OFFSET_BIT];
  assign software_dco_out = s_reg.st == ST_SOFT_DCO;
  assign ref_switch_out = s_reg.switch_p;
  assign phase_buildout_out = s_reg.buildout_p;
  assign phase_realign_out = s_reg.realign_p;
endmodule

/* shared/tx_loop_pkg.sv */
// Purpose: Constants and types shared by the transmit loop control block
// Assumes: 10 MHz system clock, 8-bit register port
// Notes: Delay figures are kept in 0.5 ms soak ticks
package tx_loop_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SOAK_TICK_NS = 500000;
  localparam int SOAK_TICK_CYCLES = (SOAK_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_REFS = 5;
  localparam int SOAK_CNT_W = 23;
  localparam int SOAK_DQ_W = 17;

  // Register byte addresses
  localparam logic [7:0] ADDR_SOAK_QUALIFY = 8'h1c;
  localparam logic [7:0] ADDR_CTRL_A = 8'h1d;
  localparam logic [7:0] ADDR_CTRL_B = 8'h1e;
  localparam logic [7:0] ADDR_MODE = 8'h1f;
  localparam logic [7:0] ADDR_REFSEL = 8'h20;

  // Reset values
  localparam logic [7:0] RST_SOAK_QUALIFY = 8'h1a;
  localparam logic [7:0] RST_CTRL_A = 8'h3a;
  localparam logic [7:0] RST_CTRL_B = 8'h04;
  localparam logic [3:0] RST_REFSEL = 4'h0;

  // Field positions
  localparam int SOAK_DQ_LSB = 0;
  localparam int SOAK_QM_LSB = 4;
  localparam int CA_HITLESS_BIT = 0;
  localparam int CA_BW_LSB = 1;
  localparam int CA_SLOPE_LSB = 4;
  localparam int CB_REVERT_BIT = 0;
  localparam int CB_OFFSET_BIT = 1;

  // Operating modes
  localparam logic [2:0] MODE_MAN_NORMAL = 3'h0;
  localparam logic [2:0] MODE_MAN_HOLDOVER = 3'h1;
  localparam logic [2:0] MODE_MAN_FREERUN = 3'h2;
  localparam logic [2:0] MODE_AUTO = 3'h3;
  localparam logic [2:0] MODE_PACKET_CLIENT = 3'h4;
  localparam logic [2:0] MODE_STRAP_HIGH = MODE_AUTO;
  localparam logic [2:0] MODE_STRAP_LOW = MODE_MAN_FREERUN;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // Bandwidth codes
  localparam logic [2:0] BW_14HZ = 3'h3;
  localparam logic [2:0] BW_28HZ = 3'h4;
  localparam logic [2:0] BW_890HZ = 3'h5;
  localparam logic [2:0] BW_RESERVED = 3'h7;

  localparam logic [3:0] PRI_DISABLED = 4'hf;

  // Disqualify delay per code, in soak ticks; code zero is immediate
  localparam logic [SOAK_DQ_W-1:0] DQ_TICKS [16] = '{
    17'd0, 17'd1, 17'd2, 17'd10, 17'd20, 17'd100, 17'd200, 17'd1000,
    17'd2000, 17'd4000, 17'd5000, 17'd8000, 17'd16000, 17'd32000, 17'd64000, 17'd128000};
  // Qualify multiplier as left shift: x2, x4, x16, x32
  localparam logic [2:0] QM_SHIFT [4] = '{3'd1, 3'd2, 3'd4, 3'd5};

  typedef enum logic [1:0] {
    ST_LOCKED,
    ST_HOLDOVER,
    ST_FREERUN,
    ST_SOFT_DCO
  } loop_state_t;
endpackage

/* tb/tx_dpll_mode_and_qualify_ctrl_tb.sv */
// Purpose: Self-checking bench for the transmit loop control block
// Assumes: Soak tick shortened to 4 cycles
// Notes: Register reads are compared by a queue monitor
`timescale 1ns/1ps
module tx_dpll_mode_and_qualify_ctrl_tb;
  import tx_loop_pkg::*;
  logic clock_in = 0, rst_in = 1, mode_pin_in = 1, wr_en_in = 0, rd_en_in = 0;
  logic [7:0] addr_in = 8'h00, wr_data_in = 8'h00, rd_data_out, rnd;
  logic [4:0] ref_fail_in = 5'h00, ref_is_2khz_in = 5'h02, ref_is_8khz_in = 5'h08;
  logic [19:0] ref_priority_in = 20'h42f13;
  logic [1:0] loop_state_out, phase_slope_limit_code_out, rd_d = 2'b00;
  logic [3:0] active_ref_out;
  logic [4:0] qualified_out;
  logic [2:0] eff_bandwidth_out;
  logic bw_limit_56hz_out, revertive_out, freq_offset_apply_out, software_dco_out;
  logic ref_switch_out, phase_buildout_out, phase_realign_out;
  logic [7:0] q[$];
  int n_fail = 0, n_checks = 0, seed = 21;
  tx_dpll_mode_and_qualify_ctrl #(.NUM_REFS(5), .TICK_CYCLES(4)) tx_dpll_mode_and_qualify_ctrl_inst (
    .clock_in(clock_in), .rst_in(rst_in), .mode_pin_in(mode_pin_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .ref_fail_in(ref_fail_in),
    .ref_priority_in(ref_priority_in), .ref_is_2khz_in(ref_is_2khz_in),
    .ref_is_8khz_in(ref_is_8khz_in), .rd_data_out(rd_data_out), .loop_state_out(loop_state_out),
    .active_ref_out(active_ref_out), .qualified_out(qualified_out),
    .eff_bandwidth_out(eff_bandwidth_out), .bw_limit_56hz_out(bw_limit_56hz_out),
    .phase_slope_limit_code_out(phase_slope_limit_code_out), .revertive_out(revertive_out),
    .freq_offset_apply_out(freq_offset_apply_out), .software_dco_out(software_dco_out),
    .ref_switch_out(ref_switch_out), .phase_buildout_out(phase_buildout_out),
    .phase_realign_out(phase_realign_out));
  initial
  begin
    forever #50 clock_in = ~clock_in;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
    repeat (2) @(negedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    q.push_back(e);
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    repeat (2) @(posedge clock_in);
  endtask
  task automatic await(input logic [1:0] s, input logic [3:0] r);
    for (int i = 0; i < 300 && !(loop_state_out === s && active_ref_out === r); i++)
      @(posedge clock_in);
    @(negedge clock_in);
    check("state", {6'h00, loop_state_out}, {6'h00, s});
    check("active", {4'h0, active_ref_out}, {4'h0, r});
  endtask
  task automatic fail_set(input logic [4:0] f);
    @(posedge clock_in);
    ref_fail_in <= f;
  endtask
  // Read results land after the read edge and stand until the next read
  always @(posedge clock_in) rd_d <= {rd_d[0], rd_en_in};
  always @(negedge clock_in)
    if (rd_d[1] && q.size() > 0)
      check("rd_data", rd_data_out, q.pop_front());
  initial
  begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    rd(ADDR_MODE, 8'h03);
    rd(ADDR_SOAK_QUALIFY, 8'h1a);
    rd(ADDR_CTRL_A, 8'h3a);
    rd(ADDR_CTRL_B, 8'h04);
    rd(ADDR_REFSEL, 8'h00);
    rd(8'h21, 8'h00);
    $display("reset values done");
    wr(ADDR_SOAK_QUALIFY, 8'hc1);
    rd(ADDR_SOAK_QUALIFY, 8'h01);
    await(2'h0, 4'h1);
    rd(ADDR_REFSEL, 8'h01);
    wr(ADDR_CTRL_A, 8'h39);
    check("eff_bw", {5'h00, eff_bandwidth_out}, 8'h03);
    wr(ADDR_CTRL_A, 8'h0f);
    rd(ADDR_CTRL_A, 8'h09);
    fail_set(5'h02);
    await(2'h0, 4'h3);
    check("eff_bw", {5'h00, eff_bandwidth_out}, 8'h04);
    wr(ADDR_CTRL_A, 8'h3b);
    check("eff_bw", {5'h00, eff_bandwidth_out}, 8'h05);
    check("lim56", {7'h00, bw_limit_56hz_out}, 8'h01);
    fail_set(5'h00);
    repeat (40) @(posedge clock_in);
    await(2'h0, 4'h3);
    wr(ADDR_CTRL_B, 8'h01);
    await(2'h0, 4'h1);
    wr(ADDR_CTRL_B, 8'h00);
    fail_set(5'h1f);
    await(2'h1, 4'h1);
    $display("automatic mode done");
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_REFSEL, 8'h00);
    await(2'h1, 4'h0);
    fail_set(5'h1e);
    await(2'h0, 4'h0);
    wr(ADDR_MODE, 8'h02);
    await(2'h2, 4'h0);
    wr(ADDR_MODE, 8'h04);
    await(2'h3, 4'h0);
    wr(ADDR_MODE, 8'h05);
    rd(ADDR_MODE, 8'h04);
    wr(ADDR_MODE, 8'h01);
    await(2'h1, 4'h0);
    $display("manual modes done");
    repeat (4)
    begin
      rnd = 8'($random(seed));
      wr(ADDR_CTRL_B, rnd);
      rd(ADDR_CTRL_B, {6'h01, rnd[1:0]});
      check("revert", {7'h00, revertive_out}, {7'h00, rnd[0]});
      check("offset", {7'h00, freq_offset_apply_out}, {7'h00, rnd[1]});
    end
    $display("control bits done");
    results;
  end
endmodule

/* tb/tx_loop_ctrl_asserts.sv */
// Purpose: Port checks for the transmit loop control block
// Assumes: Single clock domain, async reset high
// Notes: Bound to the block's top module
`timescale 1ns/1ps
module tx_loop_ctrl_asserts
  import tx_loop_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [1:0] loop_state_out,
  input wire logic [1:0] phase_slope_limit_code_out,
  input wire logic revertive_out,
  input wire logic freq_offset_apply_out,
  input wire logic software_dco_out,
  input wire logic ref_switch_out,
  input wire logic phase_buildout_out,
  input wire logic phase_realign_out
);
  logic hitless_reg;
  logic wa;
  logic wm;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  assign wa = wr_en_in && addr_in == ADDR_CTRL_A;
  assign wm = wr_en_in && addr_in == ADDR_MODE;
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      hitless_reg <= 1'b0;
    else if (wa)
      hitless_reg <= wr_data_in[0];
  slope_write_a: assert property (
    wa |=> phase_slope_limit_code_out == $past(wr_data_in[5:4])) else $error("slope not taken");
  revert_write_a: assert property (
    wr_en_in && addr_in == ADDR_CTRL_B |=> revertive_out == $past(wr_data_in[0]))
    else $error("revert bit not taken");
  offset_write_a: assert property (
    wr_en_in && addr_in == ADDR_CTRL_B |=> freq_offset_apply_out == $past(wr_data_in[1]))
    else $error("offset bit not taken");
  hitless_pulse_a: assert property (
    ref_switch_out |-> phase_realign_out == hitless_reg && phase_buildout_out == !hitless_reg)
    else $error("switch pulse gating wrong");
  switch_once_a: assert property (
    ref_switch_out |-> loop_state_out == 2'h0 ##1 !ref_switch_out) else $error("switch pulse bad");
  dco_flag_a: assert property (
    software_dco_out == (loop_state_out == 2'h3)) else $error("dco flag mismatch");
  mode_hold_a: assert property (
    wm && wr_data_in[2:0] == 3'h1 |-> ##[1:3] loop_state_out == 2'h1) else $error("no holdover");
  mode_free_a: assert property (
    wm && wr_data_in[2:0] == 3'h2 |-> ##[1:3] loop_state_out == 2'h2) else $error("no free-run");
  mode_dco_a: assert property (
    wm && wr_data_in[2:0] == 3'h4 |-> ##[1:3] software_dco_out) else $error("no dco mode");
endmodule
bind tx_dpll_mode_and_qualify_ctrl tx_loop_ctrl_asserts tx_loop_ctrl_asserts_inst (
  .clock_in(clock_in), .rst_in(rst_in), .wr_en_in(wr_en_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .loop_state_out(loop_state_out),
  .phase_slope_limit_code_out(phase_slope_limit_code_out), .revertive_out(revertive_out),
  .freq_offset_apply_out(freq_offset_apply_out), .software_dco_out(software_dco_out),
  .ref_switch_out(ref_switch_out), .phase_buildout_out(phase_buildout_out),
  .phase_realign_out(phase_realign_out));
